// ### rtl/ttcrb_phase.sv
// Machine-cycle phase generator: twelve clock phases, state-time ticks
`timescale 1ns/1ps
module ttcrb_phase (
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	input  wire logic                         ce,
	output logic [ttcrb_pkg::PH_W-1:0]        phase,
	output logic                              st_tick
);

	logic [ttcrb_pkg::PH_W-1:0] phase_r;

	// ----------------------------------------------------------------
	// Phase counter
	// ----------------------------------------------------------------
	// Wraps after the last phase of the machine cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= ttcrb_pkg::PH_ZERO;
		end else if (ce) begin
			if (phase_r == ttcrb_pkg::PH_LAST) begin
				phase_r <= ttcrb_pkg::PH_ZERO;
			end else begin
				phase_r <= phase_r + ttcrb_pkg::PH_ONE;
			end
		end
	end

	// Tick at the first clock of each two-clock state time
	assign phase   = phase_r;
	assign st_tick = ce & ~phase_r[0];

endmodule

// ### rtl/ttcrb_top.sv
// 16-bit timer/counter with capture, auto-reload, baud and clock-out modes
//
// What this block does
// - 16-bit counter, timer or event counting selectable
// - Run bit, clock selects, capture select pick mode
// - Timer function counts once per machine cycle
// - Count pin sampled each cycle, falling edge counts
// - Capture mode overflow always sets overflow flag
// - Trigger fall captures counter, sets external flag
// - Down-count enable cleared at reset
// - Up-count overflow sets flag, reloads counter
// - Trigger fall reloads counter, sets external flag
// - Trigger high with down enable counts up
// - Trigger low counts down, underflow loads FFFF
// - External flag toggles on wrap, no interrupt
// - Auto-reload lets both flags request interrupt
// - Baud timer counts every state time
// - Baud rollover reloads from reload registers
// - Baud rollover silent; trigger sets flag only
// - Clock-out drives half-duty clock on port pin
// - Clock-out period follows reload value
// - Clock-out rollovers silent, may run with baud
// - Receive and transmit clocks selected independently
// - Overflow flag never set by baud mode
// - Serial clock uses this counter or other timer
// - Interrupt request is OR of both flags, external flag masked while down-count is enabled
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module ttcrb_top (
	input  wire logic       CLK,
	input  wire logic       RST_N,
	input  wire logic       CE,
	input  wire logic [7:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	input  wire logic       PORT_PIN_I,
	output logic            PORT_PIN_O,
	output logic            PORT_PIN_OE_N,
	input  wire logic       TRIG_PIN,
	input  wire logic       TIMER1_OVF,
	output logic            RX_BAUD_CLK,
	output logic            TX_BAUD_CLK,
	output logic            INT_REQ
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0]                  ctrl_r;
	logic [1:0]                  mode_r;
	logic [15:0]                 rld_r;
	logic [15:0]                 cnt_r;
	logic [15:0]                 cnt_nxt;
	logic [7:0]                  rdata_r;
	logic                        rx_clk_r;
	logic                        tx_clk_r;
	logic                        irq_r;
	logic                        pin_out_r;
	logic                        pin_oe_n_r;
	logic [1:0]                  pin_raw;
	logic [1:0]                  sync1_r;
	logic [1:0]                  sync2_r;
	logic                        cnt_smp_r;
	logic                        cnt_fall_r;
	logic                        trg_smp_r;
	logic                        trg_fall_r;
	logic [ttcrb_pkg::PH_W-1:0]  phase;
	logic                        st_tick;
	ttcrb_pkg::ttcrb_mode_t      md;
	logic                        run;
	logic                        baud;
	logic                        cntsel;
	logic                        down_count_enable;
	logic                        clkout;
	logic                        fast;
	logic                        reload_mode;
	logic                        capture_mode;
	logic                        updown;
	logic                        count_down;
	logic                        upd_slot;
	logic                        cnt_evt;
	logic                        step;
	logic                        ovf;
	logic                        unf;
	logic                        ex_evt;
	logic                        trig_reload;
	logic                        cap_evt;
	logic                        tf_set;
	logic                        ex_tog;
	logic                        bd_pulse;
	logic                        wr_ctrl;
	logic                        wr_mode;
	logic                        wr_rlo;
	logic                        wr_rhi;
	logic                        wr_clo;
	logic                        wr_chi;
	logic                        post_rst_r;

	// ----------------------------------------------------------------
	// Phase generator
	// ----------------------------------------------------------------
	ttcrb_phase u_phase (
		.clk     (CLK),
		.rst_n   (RST_N),
		.ce      (CE),
		.phase   (phase),
		.st_tick (st_tick)
	);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Count pin on bit 0, trigger pin on bit 1
	assign pin_raw = {TRIG_PIN, PORT_PIN_I};

	generate
		for (genvar i = 0; i < 2; i++) begin : g_sync
			// Two flops before any logic reads the pin
			always_ff @(posedge CLK or negedge RST_N) begin
				if (!RST_N) begin
					sync1_r[i] <= 1'b0;
					sync2_r[i] <= 1'b0;
				end else if (CE) begin
					sync1_r[i] <= pin_raw[i];
					sync2_r[i] <= sync1_r[i];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Edge sampling at the sample phase
	// ----------------------------------------------------------------
	// High in one sample and low in the next marks a falling edge
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cnt_smp_r  <= 1'b0;
			cnt_fall_r <= 1'b0;
			trg_smp_r  <= 1'b0;
			trg_fall_r <= 1'b0;
		end else if (CE && phase == ttcrb_pkg::PH_SAMPLE) begin
			cnt_smp_r  <= sync2_r[0];
			cnt_fall_r <= cnt_smp_r & ~sync2_r[0];
			trg_smp_r  <= sync2_r[1];
			trg_fall_r <= trg_smp_r & ~sync2_r[1];
		end
	end

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	// Mode selection and counting source
	assign md      = ttcrb_pkg::mode_of(ctrl_r);
	assign run     = ctrl_r[ttcrb_pkg::CTRL_RUN];
	assign baud    = ctrl_r[ttcrb_pkg::CTRL_RXSEL] |
	                 ctrl_r[ttcrb_pkg::CTRL_TXSEL];
	assign cntsel  = ctrl_r[ttcrb_pkg::CTRL_CNTSEL];
	assign down_count_enable    = mode_r[ttcrb_pkg::MODE_DOWN_COUNT_ENABLE];
	assign clkout  = mode_r[ttcrb_pkg::MODE_OE] & ~cntsel;
	assign fast    = (baud | clkout) & ~cntsel;
	assign reload_mode  = (md == ttcrb_pkg::MD_BAUD) |
	                      (md == ttcrb_pkg::MD_RELOAD) |
	                      ((md == ttcrb_pkg::MD_CAPTURE) & clkout);
	assign capture_mode = (md == ttcrb_pkg::MD_CAPTURE) & ~clkout;
	assign updown       = (md == ttcrb_pkg::MD_RELOAD) & down_count_enable & ~clkout;
	assign count_down   = updown & ~sync2_r[1];

	// ----------------------------------------------------------------
	// Count step and events
	// ----------------------------------------------------------------
	// One step per machine cycle, per state time, or per pin edge
	assign upd_slot = CE & (phase == ttcrb_pkg::PH_UPDATE);
	assign cnt_evt  = upd_slot & cnt_fall_r;
	assign step     = run & (cntsel ? cnt_evt :
	                  (fast ? st_tick : upd_slot));
	assign ovf      = step & ~count_down & (cnt_r == ttcrb_pkg::CNT_MAX);
	assign unf      = step & count_down & (cnt_r == rld_r);

	// Trigger edge is ignored while it steers the count direction
	assign ex_evt      = run & upd_slot & trg_fall_r & ~updown &
	                     ctrl_r[ttcrb_pkg::CTRL_EXEN];
	assign trig_reload = ex_evt & (md == ttcrb_pkg::MD_RELOAD) &
	                     ~clkout;
	assign cap_evt     = ex_evt & capture_mode;

	// Flag events; baud and clock-out rollovers stay silent
	assign tf_set   = (ovf | unf) & ~baud & ~clkout;
	assign ex_tog   = updown & (ovf | unf);
	assign bd_pulse = ovf & baud;

	// ----------------------------------------------------------------
	// Next counter value
	// ----------------------------------------------------------------
	// Overflow reload takes priority, so a coincident trigger reloads once
	always_comb begin
		cnt_nxt = cnt_r;
		if (ovf) begin
			cnt_nxt = reload_mode ? rld_r : ttcrb_pkg::CNT_ZERO;
		end else if (unf) begin
			cnt_nxt = ttcrb_pkg::CNT_MAX;
		end else if (trig_reload) begin
			cnt_nxt = rld_r;
		end else if (step) begin
			if (count_down) begin
				cnt_nxt = cnt_r - ttcrb_pkg::CNT_ONE;
			end else begin
				cnt_nxt = cnt_r + ttcrb_pkg::CNT_ONE;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register write decode
	// ----------------------------------------------------------------
	assign wr_ctrl = CE & WR & (ADDR == ttcrb_pkg::ADDR_CTRL);
	assign wr_mode = CE & WR & (ADDR == ttcrb_pkg::ADDR_MODE);
	assign wr_rlo  = CE & WR & (ADDR == ttcrb_pkg::ADDR_RLD_LO);
	assign wr_rhi  = CE & WR & (ADDR == ttcrb_pkg::ADDR_RLD_HI);
	assign wr_clo  = CE & WR & (ADDR == ttcrb_pkg::ADDR_CNT_LO);
	assign wr_chi  = CE & WR & (ADDR == ttcrb_pkg::ADDR_CNT_HI);

	// ----------------------------------------------------------------
	// Control register and flags
	// ----------------------------------------------------------------
	// Hardware flag events win over a software write in the same cycle
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_r <= ttcrb_pkg::CTRL_RESET;
		end else if (CE) begin
			if (wr_ctrl) begin
				ctrl_r <= WDATA;
			end
			if (tf_set) begin
				ctrl_r[ttcrb_pkg::CTRL_OVF] <= 1'b1;
			end
			if (ex_evt) begin
				ctrl_r[ttcrb_pkg::CTRL_EXT] <= 1'b1;
			end else if (ex_tog) begin
				ctrl_r[ttcrb_pkg::CTRL_EXT] <=
					~ctrl_r[ttcrb_pkg::CTRL_EXT];
			end
		end
	end

	// Mode register; down-count starts disabled
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			mode_r <= ttcrb_pkg::MODE_RESET;
		end else if (wr_mode) begin
			mode_r <= WDATA[1:0];
		end
	end

	// ----------------------------------------------------------------
	// Reload/capture and counter registers
	// ----------------------------------------------------------------
	// Capture copies both counter bytes; it wins over a write
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rld_r <= ttcrb_pkg::WORD_RESET;
		end else if (cap_evt) begin
			rld_r <= cnt_r;
		end else if (wr_rlo) begin
			rld_r[7:0] <= WDATA;
		end else if (wr_rhi) begin
			rld_r[15:8] <= WDATA;
		end
	end

	// A software byte write replaces its byte; the other byte still takes the count step
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cnt_r <= ttcrb_pkg::WORD_RESET;
		end else if (CE) begin
			if (wr_clo) begin
				cnt_r <= {cnt_nxt[15:8], WDATA};
			end else if (wr_chi) begin
				cnt_r <= {WDATA, cnt_nxt[7:0]};
			end else begin
				cnt_r <= cnt_nxt;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	// Read data stand in the cycle after the strobe only
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_r <= ttcrb_pkg::READ_NONE;
		end else if (CE) begin
			if (!RD) begin
				rdata_r <= ttcrb_pkg::READ_NONE;
			end else if (ADDR == ttcrb_pkg::ADDR_CTRL) begin
				rdata_r <= ctrl_r;
			end else if (ADDR == ttcrb_pkg::ADDR_MODE) begin
				rdata_r <= {ttcrb_pkg::MODE_PAD, mode_r};
			end else if (ADDR == ttcrb_pkg::ADDR_RLD_LO) begin
				rdata_r <= rld_r[7:0];
			end else if (ADDR == ttcrb_pkg::ADDR_RLD_HI) begin
				rdata_r <= rld_r[15:8];
			end else if (ADDR == ttcrb_pkg::ADDR_CNT_LO) begin
				rdata_r <= cnt_r[7:0];
			end else if (ADDR == ttcrb_pkg::ADDR_CNT_HI) begin
				rdata_r <= cnt_r[15:8];
			end else begin
				rdata_r <= ttcrb_pkg::READ_NONE;
			end
		end
	end

	// ----------------------------------------------------------------
	// Serial clocks, clock-out pin and interrupt request
	// ----------------------------------------------------------------
	// Each direction picks its own overflow source
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rx_clk_r <= 1'b0;
			tx_clk_r <= 1'b0;
		end else if (CE) begin
			rx_clk_r <= ctrl_r[ttcrb_pkg::CTRL_RXSEL] ?
			            bd_pulse : TIMER1_OVF;
			tx_clk_r <= ctrl_r[ttcrb_pkg::CTRL_TXSEL] ?
			            bd_pulse : TIMER1_OVF;
		end
	end

	// Toggle on every rollover gives a half-duty clock
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pin_out_r  <= ttcrb_pkg::PIN_IDLE;
			pin_oe_n_r <= 1'b1;
		end else if (CE) begin
			pin_oe_n_r <= ~clkout;
			if (!clkout) begin
				pin_out_r <= ttcrb_pkg::PIN_IDLE;
			end else if (ovf) begin
				pin_out_r <= ~pin_out_r;
			end
		end
	end

	// External flag does not request while down-count is enabled
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			irq_r <= 1'b0;
		end else if (CE) begin
			irq_r <= ctrl_r[ttcrb_pkg::CTRL_OVF] |
			         (ctrl_r[ttcrb_pkg::CTRL_EXT] & ~down_count_enable);
		end
	end

	assign RDATA         = rdata_r;
	assign RX_BAUD_CLK   = rx_clk_r;
	assign TX_BAUD_CLK   = tx_clk_r;
	assign PORT_PIN_O    = pin_out_r;
	assign PORT_PIN_OE_N = pin_oe_n_r;
	assign INT_REQ       = irq_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Marks the cycles after the first edge out of reset
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			post_rst_r <= 1'b0;
		end else begin
			post_rst_r <= 1'b1;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	sequence s_wrap_up;
		step && !count_down && cnt_r == ttcrb_pkg::CNT_MAX && reload_mode;
	endsequence

	sequence s_no_sw_cnt;
		!wr_clo && !wr_chi;
	endsequence

	down_count_enable_reset_a: assert property (
		!post_rst_r |-> !mode_r[ttcrb_pkg::MODE_DOWN_COUNT_ENABLE])
		else $error("down-count enable not clear after reset");

	slow_step_a: assert property (
		(step && !cntsel && !fast) |-> phase == ttcrb_pkg::PH_UPDATE)
		else $error("timer step outside update phase");

	ovf_flag_a: assert property (
		($rose(ctrl_r[ttcrb_pkg::CTRL_OVF]) && !$past(wr_ctrl)) |->
		($past(ovf || unf) && !$past(baud)))
		else $error("overflow flag set without cause");

	reload_wrap_a: assert property (
		(s_wrap_up and s_no_sw_cnt) |=> cnt_r == $past(rld_r))
		else $error("counter not reloaded on overflow");

	down_wrap_a: assert property (
		(unf && !wr_clo && !wr_chi) |=> cnt_r == ttcrb_pkg::CNT_MAX)
		else $error("counter not set to all ones on underflow");

	capture_copy_a: assert property (
		cap_evt |=> rld_r == $past(cnt_r) ##0
		ctrl_r[ttcrb_pkg::CTRL_EXT])
		else $error("capture did not copy counter or set flag");

	ext_toggle_a: assert property (
		(ex_tog && !wr_ctrl) |=>
		ctrl_r[ttcrb_pkg::CTRL_EXT] != $past(ctrl_r[ttcrb_pkg::CTRL_EXT]))
		else $error("external flag did not toggle on wrap");

	pin_idle_a: assert property (
		!clkout |=> PORT_PIN_OE_N && PORT_PIN_O == ttcrb_pkg::PIN_IDLE)
		else $error("port pin driven outside clock-out");

	irq_or_a: assert property (
		CE |=> INT_REQ == ($past(ctrl_r[ttcrb_pkg::CTRL_OVF]) ||
		($past(ctrl_r[ttcrb_pkg::CTRL_EXT]) && !$past(down_count_enable))))
		else $error("interrupt request not OR of flags");

	baud_hold_a: assert property (
		(baud && ex_evt && !step && !wr_clo && !wr_chi) |=>
		$stable(cnt_r))
		else $error("trigger edge reloaded counter in baud mode");

endmodule

// ### shared/ttcrb_pkg.sv
// Constants, register map and mode decode for the 16-bit capture/reload timer
package ttcrb_pkg;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'hC8; // counter_control_register
	localparam logic [7:0] ADDR_MODE   = 8'hC9; // counter_mode_register
	localparam logic [7:0] ADDR_RLD_LO = 8'hCA; // reload_low_byte
	localparam logic [7:0] ADDR_RLD_HI = 8'hCB; // reload_high_byte
	localparam logic [7:0] ADDR_CNT_LO = 8'hCC; // counter_low_byte
	localparam logic [7:0] ADDR_CNT_HI = 8'hCD; // counter_high_byte

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_OVF    = 7; // overflow_flag
	localparam int CTRL_EXT    = 6; // external_event_flag
	localparam int CTRL_RXSEL  = 5; // receive clock select
	localparam int CTRL_TXSEL  = 4; // transmit_clock_select
	localparam int CTRL_EXEN   = 3; // external_trigger_enable
	localparam int CTRL_RUN    = 2; // run_bit
	localparam int CTRL_CNTSEL = 1; // counter_timer_select
	localparam int CTRL_CAPSEL = 0; // capture_reload_select
	localparam int MODE_OE     = 1; // clock_output_enable
	localparam int MODE_DOWN_COUNT_ENABLE   = 0; // down_count_enable

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  CTRL_RESET = 8'h00;
	localparam logic [1:0]  MODE_RESET = 2'h0;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [7:0]  READ_NONE  = 8'h00;
	localparam logic [5:0]  MODE_PAD   = 6'h00;
	localparam logic        PIN_IDLE   = 1'b1;

	// ----------------------------------------------------------------
	// Counter limits
	// ----------------------------------------------------------------
	localparam logic [15:0] CNT_MAX  = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE  = 16'h0001;

	// ----------------------------------------------------------------
	// Timing: clock is the oscillator, one machine cycle is 12 periods
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int MC_NS         = 1200;
	localparam int MC_CYCLES     = MC_NS / CLK_PERIOD_NS;
	localparam int PH_W          = 4;
	localparam logic [PH_W-1:0] PH_LAST   = PH_W'(MC_CYCLES - 1);
	localparam logic [PH_W-1:0] PH_ZERO   = 4'h0;
	localparam logic [PH_W-1:0] PH_ONE    = 4'h1;
	localparam logic [PH_W-1:0] PH_UPDATE = 4'h4; // update_phase
	localparam logic [PH_W-1:0] PH_SAMPLE = 4'h9; // sample_phase

	// ----------------------------------------------------------------
	// Operating modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MD_OFF,
		MD_CAPTURE,
		MD_RELOAD,
		MD_BAUD
	} ttcrb_mode_t;

	// Mode from the control register
	function automatic ttcrb_mode_t mode_of(input logic [7:0] ctrl);
		ttcrb_mode_t m;
		m = MD_OFF;
		if (!ctrl[CTRL_RUN]) begin
			m = MD_OFF;
		end else if (ctrl[CTRL_RXSEL] | ctrl[CTRL_TXSEL]) begin
			m = MD_BAUD;
		end else if (ctrl[CTRL_CAPSEL]) begin
			m = MD_CAPTURE;
		end else begin
			m = MD_RELOAD;
		end
		return m;
	endfunction

endpackage

// ### tb/testbench.sv
// Self-checking bench for the capture/reload timer block
`timescale 1ns/1ps
module testbench;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr_s = 1'b0;
	logic        rd_s = 1'b0;
	logic        cnt_run = 1'b0;
	logic        trig_lvl = 1'b1;
	logic [7:0]  rdata, d;
	logic        pin_i, pin_o, pin_oe_n, trig, t1, rxc, txc, irq, q;
	logic [15:0] r, c;
	int          falls, f0, n, err_count = 0, n_checks = 0;
	int          t1_n = 0, rx_n = 0, seed = 86;

	ttcrb_top dut (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .ADDR(addr),
		.WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
		.PORT_PIN_I(pin_i), .PORT_PIN_O(pin_o), .PORT_PIN_OE_N(pin_oe_n),
		.TRIG_PIN(trig), .TIMER1_OVF(t1), .RX_BAUD_CLK(rxc),
		.TX_BAUD_CLK(txc), .INT_REQ(irq));
	ttcrb_partner far (.clk(clk), .rst_n(rst_n), .cnt_run(cnt_run),
		.trig_lvl(trig_lvl), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
		.pin_i(pin_i), .trig(trig), .t1_ovf(t1), .falls(falls));

	// ----------------------------------------
	// Clock, pulse counters and helpers
	// ----------------------------------------
	always #50 clk = ~clk;
	// Count pulses at the falling edge, clear of the launching edge
	always @(negedge clk) begin
		if (t1 === 1'b1) t1_n++;
		if (rxc === 1'b1) rx_n++;
	end
	// Expected count after k steps, upward with reload or downward
	function automatic logic [15:0] steps(input logic [15:0] s,
		input logic [15:0] rl, input int k, input logic dn);
		for (int i = 0; i < k; i++) begin
			if (dn) s = (s == rl) ? 16'hFFFF : s - 16'h0001;
			else s = (s == 16'hFFFF) ? rl : s + 16'h0001;
		end
		return s;
	endfunction
	task automatic conclude();
		if (err_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		@(posedge clk);
	endtask
	// Read: data and interrupt line sampled in the cycle after
	task automatic rd(input logic [7:0] a);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 d = rdata;
		q = irq;
		@(posedge clk);
	endtask
	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 8'h01, v[15:8]);
	endtask
	task automatic rd16(input logic [7:0] a);
		rd(a);
		c[7:0] = d;
		rd(a + 8'h01);
		c[15:8] = d;
	endtask
	// Run 48 clocks: four machine cycles or 24 state times
	task automatic run48(input logic [7:0] ctl, input logic fall);
		wr(8'hC8, ctl);
		if (fall) trig_lvl <= 1'b0;
		repeat (44) @(posedge clk);
		rd(8'hC8);
		wr(8'hC8, 8'h00);
	endtask
	// Clocks until the shared pin output changes, bounded
	task automatic tog(output int m);
		logic p;
		p = pin_o;
		m = 0;
		while (pin_o === p && m < 300) begin
			@(posedge clk);
			#1 m++;
		end
		if (m >= 300) begin
			err_count++;
			conclude();
		end
	endtask
	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		conclude();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		wr(8'hCE, 8'hFF);
		for (int a = 0; a < 7; a++) begin
			rd(8'hC8 + 8'(a));
			chk(d, 8'h00);
		end
		chk({irq, pin_o, pin_oe_n}, 16'h0003);
		// Timer auto-reload counting up through an overflow
		r = 16'($random(seed)) & 16'h7FFF;
		wr16(8'hCA, r);
		wr16(8'hCC, 16'hFFFF);
		run48(8'h04, 1'b0);
		chk(d, 8'h84);
		chk(q, 1'b1);
		rd16(8'hCC);
		chk(c, steps(16'hFFFF, r, 4, 1'b0));
		// Baud generation with a trigger fall in mid-run
		r = 16'($random(seed)) & 16'h7FFF;
		wr16(8'hCA, r);
		wr16(8'hCC, 16'hFFFF);
		run48(8'h1C, 1'b1);
		chk(d, 8'h5C);
		rd16(8'hCC);
		chk(c, steps(16'hFFFF, r, 24, 1'b0));
		trig_lvl <= 1'b1;
		// Down counting through an underflow
		wr(8'hC9, 8'h01);
		trig_lvl <= 1'b0;
		repeat (30) @(posedge clk);
		r = 16'($random(seed)) & 16'h7FFF;
		wr16(8'hCA, r);
		wr16(8'hCC, r + 16'h0002);
		run48(8'h04, 1'b0);
		chk(d, 8'hC4);
		rd16(8'hCC);
		chk(c, steps(r + 16'h0002, r, 4, 1'b1));
		wr(8'hC9, 8'h00);
		trig_lvl <= 1'b1;
		// Event counting across a wrap, then a capture
		repeat (30) @(posedge clk);
		wr16(8'hCC, 16'hFFFE);
		wr(8'hC8, 8'h0F);
		f0 = falls;
		cnt_run <= 1'b1;
		repeat (78) @(posedge clk);
		cnt_run <= 1'b0;
		repeat (40) @(posedge clk);
		trig_lvl <= 1'b0;
		repeat (40) @(posedge clk);
		rd(8'hC8);
		chk(d, 8'hCF);
		r = 16'hFFFE + 16'(falls - f0);
		rd16(8'hCA);
		chk(c, r);
		rd16(8'hCC);
		chk(c, r);
		wr(8'hC8, 8'h00);
		trig_lvl <= 1'b1;
		// Clock output on the shared pin
		r = 16'hFFE0 | (16'($random(seed)) & 16'h000F);
		wr16(8'hCA, r);
		wr16(8'hCC, r);
		wr(8'hC9, 8'h02);
		wr(8'hC8, 8'h04);
		tog(n);
		tog(n);
		chk(16'(n), 16'(2 * (65536 - r)));
		chk(pin_oe_n, 1'b0);
		rd(8'hC8);
		chk(d, 8'h04);
		wr(8'hC8, 8'h00);
		wr(8'hC9, 8'h00);
		// Trigger fall reloads an up-counting auto-reload timer
		r = 16'($random(seed)) & 16'h7FFF;
		wr16(8'hCA, r);
		wr16(8'hCC, r);
		run48(8'h0C, 1'b1);
		chk(d, 8'h4C);
		chk(q, 1'b1);
		rd16(8'hCC);
		chk(c - r < 16'h0004, 1'b1);
		trig_lvl <= 1'b1;
		#1 chk(rx_n == t1_n || rx_n + 1 == t1_n, 1'b1);
		conclude();
	end
endmodule

// ### tb/ttcrb_partner.sv
// Far-side model: count source, trigger pin and second timer
`timescale 1ns/1ps
module ttcrb_partner (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic cnt_run,
	input  wire logic trig_lvl,
	input  wire logic pin_o,
	input  wire logic pin_oe_n,
	output logic      pin_i,
	output logic      trig,
	output logic      t1_ovf,
	output int        falls
);
	logic [3:0] hold_r;
	logic [5:0] t1_r;
	logic       lvl_r;
	// Count source: each level held twelve clocks, pulled high when idle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_r <= 4'h0;
			lvl_r  <= 1'b1;
			falls  <= 0;
		end else if (!cnt_run) begin
			hold_r <= 4'h0;
			lvl_r  <= 1'b1;
		end else begin
			hold_r <= (hold_r == 4'hB) ? 4'h0 : hold_r + 4'h1;
			if (hold_r == 4'hB) begin
				lvl_r <= ~lvl_r;
				falls <= falls + (lvl_r ? 1 : 0);
			end
		end
	end
	// Second timer overflows once every forty clocks
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			t1_r <= 6'h00;
		end else begin
			t1_r <= (t1_r == 6'h27) ? 6'h00 : t1_r + 6'h01;
		end
	end
	// Shared pin follows the block only while it drives
	assign t1_ovf = (t1_r == 6'h27);
	assign pin_i  = pin_oe_n ? lvl_r : pin_o;
	assign trig   = trig_lvl;
endmodule
